/* shared/asr_regs.svh */
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_ADDR_CTRL_A  8'h13
`define ASR_ADDR_CTRL_B  8'h14
`define ASR_ADDR_CTRL_C  8'h15
`define ASR_ADDR_FLAGS_A 8'h16
`define ASR_ADDR_FLAGS_B 8'h17
`define ASR_ADDR_BUFFER  8'h18
`define ASR_ADDR_BAUD    8'h19

`define ASR_CA_ENABLE    6
`define ASR_CA_CHAR_LEN  4
`define ASR_CA_WAKE      3
`define ASR_CA_IDLE_ORG  2
`define ASR_CB_FULL_IE   5
`define ASR_CB_IDLE_IE   4
`define ASR_CB_RX_EN     2
`define ASR_CB_STANDBY   1
`define ASR_CC_OR_IE     3
`define ASR_CC_NF_IE     2
`define ASR_CC_FE_IE     1
`define ASR_CC_RW_MASK   8'h4F

`define ASR_RST_BYTE     8'h00

`define ASR_RT_FIRST     5'h01
`define ASR_RT_VERIFY    5'h07
`define ASR_RT_VOTE      5'h0A
`define ASR_RT_LAST      5'h10
`define ASR_IDLE_BITS_8  4'hA
`define ASR_IDLE_BITS_9  4'hB
`endif

/* shared/asr_pkg.sv */
package asr_pkg;
  typedef enum logic [3:0] {
    ASR_HUNT  = 4'b0001,
    ASR_START = 4'b0010,
    ASR_DATA  = 4'b0100,
    ASR_STOP  = 4'b1000
  } asr_state_e;
  typedef logic [7:0] asr_byte_t;
endpackage

/* verilog/asr_rt_tick.sv */
`timescale 1ns/100ps
module asr_rt_tick #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             clk_en_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divider_i,
  output logic                  tick_o
);
  logic [DIV_W-1:0] cnt_q;
  wire              wrap = (cnt_q == divider_i);

  // one oversample tick every divider_i + 1 clocks
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!run_i || wrap) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
      tick_o <= run_i && wrap;
    end
  end
endmodule // asr_rt_tick

/* verilog/asr_receiver.sv */
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_receiver (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic wr_i,
  input  wire logic rd_i,
  output logic [7:0] rdata_o,
  input  wire logic receive_pin_i,
  output logic rx_irq_o,
  output logic err_irq_o
);
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  // pin synchroniser
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else if (clk_en_i) begin
      rx_meta_q <= receive_pin_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  // register state
  asr_pkg::asr_byte_t ctrl_a_q;
  asr_pkg::asr_byte_t ctrl_b_q;
  asr_pkg::asr_byte_t ctrl_c_q;
  asr_pkg::asr_byte_t baud_q;
  asr_pkg::asr_byte_t buf_q;
  asr_pkg::asr_byte_t rd_mux;
  logic               ninth_q;
  logic               full_q;
  logic               idle_q;
  logic               or_q;
  logic               nf_q;
  logic               fe_q;
  logic               brk_q;

  wire sel_a    = (addr_i == `ASR_ADDR_CTRL_A);
  wire sel_b    = (addr_i == `ASR_ADDR_CTRL_B);
  wire sel_c    = (addr_i == `ASR_ADDR_CTRL_C);
  wire sel_fa   = (addr_i == `ASR_ADDR_FLAGS_A);
  wire sel_fb   = (addr_i == `ASR_ADDR_FLAGS_B);
  wire sel_buf  = (addr_i == `ASR_ADDR_BUFFER);
  wire sel_baud = (addr_i == `ASR_ADDR_BAUD);
  wire wr_b     = wr_i && sel_b;
  wire rd_buf   = rd_i && sel_buf;

  wire rx_on     = ctrl_a_q[`ASR_CA_ENABLE] && ctrl_b_q[`ASR_CB_RX_EN];
  wire len9      = ctrl_a_q[`ASR_CA_CHAR_LEN];
  wire wake_mark = ctrl_a_q[`ASR_CA_WAKE];
  wire idle_org  = ctrl_a_q[`ASR_CA_IDLE_ORG];
  wire standby   = ctrl_b_q[`ASR_CB_STANDBY];

  // oversample tick
  logic rt_tick;
  asr_rt_tick #(
    .DIV_W(8)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .reset_i  (reset_i),
    .clk_en_i (clk_en_i),
    .run_i    (rx_on),
    .divider_i(baud_q),
    .tick_o   (rt_tick)
  );

  // recovery state
  asr_pkg::asr_state_e state_q;
  asr_pkg::asr_state_e state_d;
  logic [4:0]          rt_q;
  logic [4:0]          rt_d;
  logic [2:0]          win_q;
  logic [2:0]          win_d;
  logic [2:0]          hist_q;
  logic [2:0]          hist_d;
  logic [3:0]          bits_q;
  logic [3:0]          bits_d;
  logic [8:0]          shift_q;
  logic [8:0]          shift_d;
  logic                nf_acc_q;
  logic                nf_acc_d;
  logic                prev_bit_q;
  logic                prev_bit_d;
  logic                prev_smp_q;
  logic [4:0]          age_q;
  logic                done;
  logic                stop_bad;
  logic                stop_noise;

  wire       smp      = rx_sync_q;
  wire [2:0] trio     = {win_q[1:0], smp};
  wire       smp_pt   = (rt_q == 5'h03) || (rt_q == 5'h05) ||
                        (rt_q == 5'h08) || (rt_q == 5'h09);
  wire [4:0] rt_next  = (rt_q == `ASR_RT_LAST) ? `ASR_RT_FIRST
                                               : 5'(rt_q + 5'h01);
  wire       falling  = prev_smp_q && !smp;
  wire [4:0] age_now  = falling ? 5'h00
                      : ((age_q == 5'h1F) ? age_q : 5'(age_q + 5'h01));
  wire [3:0] nbits    = len9 ? 4'h9 : 4'h8;
  wire       bit_val  = maj3(trio);

  always_comb begin
    state_d    = state_q;
    rt_d       = rt_q;
    win_d      = win_q;
    hist_d     = hist_q;
    bits_d     = bits_q;
    shift_d    = shift_q;
    nf_acc_d   = nf_acc_q;
    prev_bit_d = prev_bit_q;
    done       = 1'b0;
    stop_bad   = 1'b0;
    stop_noise = 1'b0;
    if (!rx_on) begin
      state_d = asr_pkg::ASR_HUNT;
      hist_d  = 3'b000;
    end else if (rt_tick) begin
      if (smp_pt) begin
        win_d = {win_q[1:0], smp};
      end
      rt_d = rt_next;
      case (state_q)
        asr_pkg::ASR_HUNT: begin
          hist_d = {hist_q[1:0], smp};
          rt_d   = `ASR_RT_FIRST;
          if (!smp && hist_q == 3'b111) begin
            state_d    = asr_pkg::ASR_START;
            rt_d       = 5'h02;
            bits_d     = 4'h0;
            shift_d    = 9'h000;
            nf_acc_d   = 1'b0;
            prev_bit_d = 1'b0;
          end
        end
        asr_pkg::ASR_START: begin
          if (rt_q == `ASR_RT_VERIFY) begin
            if (maj3(trio)) begin
              state_d = asr_pkg::ASR_HUNT;
              hist_d  = 3'b000;
            end else if (split3(trio)) begin
              nf_acc_d = 1'b1;
            end
          end
          if (rt_q == `ASR_RT_VOTE && trio != 3'b000) begin
            nf_acc_d = 1'b1;
          end
          if (rt_q == `ASR_RT_LAST) begin
            state_d = asr_pkg::ASR_DATA;
          end
        end
        asr_pkg::ASR_DATA: begin
          if (rt_q == `ASR_RT_VOTE) begin
            shift_d    = {bit_val, shift_q[8:1]};
            prev_bit_d = bit_val;
            bits_d     = 4'(bits_q + 4'h1);
            if (split3(trio)) begin
              nf_acc_d = 1'b1;
            end
            if (prev_bit_q && !bit_val && age_now < 5'h0F) begin
              rt_d = 5'(age_now + 5'h02);
            end
          end
          if (rt_q == `ASR_RT_LAST && bits_q == nbits) begin
            state_d = asr_pkg::ASR_STOP;
          end
        end
        asr_pkg::ASR_STOP: begin
          if (rt_q == `ASR_RT_VOTE) begin
            done       = 1'b1;
            stop_bad   = !bit_val;
            stop_noise = split3(trio);
            state_d    = asr_pkg::ASR_HUNT;
            hist_d     = 3'b000;
          end
        end
        default: begin
          state_d = asr_pkg::ASR_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q    <= asr_pkg::ASR_HUNT;
      rt_q       <= `ASR_RT_FIRST;
      win_q      <= 3'b000;
      hist_q     <= 3'b000;
      bits_q     <= 4'h0;
      shift_q    <= 9'h000;
      nf_acc_q   <= 1'b0;
      prev_bit_q <= 1'b0;
      prev_smp_q <= 1'b1;
      age_q      <= 5'h1F;
    end else if (clk_en_i) begin
      state_q    <= state_d;
      rt_q       <= rt_d;
      win_q      <= win_d;
      hist_q     <= hist_d;
      bits_q     <= bits_d;
      shift_q    <= shift_d;
      nf_acc_q   <= nf_acc_d;
      prev_bit_q <= prev_bit_d;
      if (rt_tick) begin
        prev_smp_q <= smp;
        age_q      <= age_now;
      end
    end
  end

  // character outcome
  wire [7:0] rx_data  = len9 ? shift_q[7:0] : shift_q[8:1];
  wire       rx_msb   = shift_q[8];
  wire       is_break = stop_bad && (shift_q == 9'h000);
  wire       char_nf  = nf_acc_q || stop_noise;
  wire       wake_hit = done && standby && wake_mark && rx_msb;
  wire       accept   = done && (!standby || wake_hit);
  wire       load     = accept && !full_q;
  wire       overrun  = accept && full_q;

  // idle detection
  logic [7:0] idle_cnt_q;
  logic       idle_armed_q;
  wire  [7:0] idle_tgt  = {(len9 ? `ASR_IDLE_BITS_9 : `ASR_IDLE_BITS_8),
                           4'h0};
  wire        idle_hold = idle_org && (state_q != asr_pkg::ASR_HUNT);
  wire        idle_full = (idle_cnt_q >= idle_tgt);
  wire        idle_hit  = rx_on && rt_tick && smp && !idle_hold &&
                          (idle_cnt_q == 8'(idle_tgt - 8'h01));
  wire        idle_set  = idle_hit && idle_armed_q && !standby;
  wire        idle_wake = rx_on && standby && !wake_mark && idle_full;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      idle_cnt_q   <= 8'h00;
      idle_armed_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!rx_on) begin
        idle_cnt_q <= 8'h00;
      end else if (rt_tick) begin
        if (!smp || idle_hold) begin
          idle_cnt_q <= 8'h00;
        end else if (!idle_full) begin
          idle_cnt_q <= 8'(idle_cnt_q + 8'h01);
        end
      end
      if (done) begin
        idle_armed_q <= 1'b1;
      end else if (idle_hit) begin
        idle_armed_q <= 1'b0;
      end
    end
  end

  // registers and flags
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_a_q <= `ASR_RST_BYTE;
      ctrl_b_q <= `ASR_RST_BYTE;
      ctrl_c_q <= `ASR_RST_BYTE;
      baud_q   <= `ASR_RST_BYTE;
      buf_q    <= `ASR_RST_BYTE;
      ninth_q  <= 1'b0;
      full_q   <= 1'b0;
      idle_q   <= 1'b0;
      or_q     <= 1'b0;
      nf_q     <= 1'b0;
      fe_q     <= 1'b0;
      brk_q    <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_i && sel_a) begin
        ctrl_a_q <= wdata_i;
      end
      if (wr_b) begin
        ctrl_b_q <= wdata_i;
      end else if (wake_hit || idle_wake) begin
        ctrl_b_q[`ASR_CB_STANDBY] <= 1'b0;
      end
      if (wr_i && sel_c) begin
        ctrl_c_q <= wdata_i & `ASR_CC_RW_MASK;
      end
      if (wr_i && sel_baud) begin
        baud_q <= wdata_i;
      end
      if (load) begin
        buf_q   <= rx_data;
        ninth_q <= rx_msb;
      end
      full_q <= load || (full_q && !rd_buf);
      fe_q   <= (load && stop_bad) || (fe_q && !rd_buf);
      nf_q   <= (load && char_nf) || (nf_q && !rd_buf);
      brk_q  <= (load && is_break) || (brk_q && !rd_buf);
      or_q   <= overrun || (or_q && !rd_buf);
      idle_q <= idle_set || (idle_q && !rd_buf);
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (sel_a) begin
      rd_mux = ctrl_a_q;
    end else if (sel_b) begin
      rd_mux = ctrl_b_q;
    end else if (sel_c) begin
      rd_mux = {ninth_q, ctrl_c_q[6:0]};
    end else if (sel_fa) begin
      rd_mux = {2'b00, full_q, idle_q, or_q, nf_q, fe_q, 1'b0};
    end else if (sel_fb) begin
      rd_mux = {6'h00, brk_q, (state_q != asr_pkg::ASR_HUNT)};
    end else if (sel_buf) begin
      rd_mux = buf_q;
    end else if (sel_baud) begin
      rd_mux = baud_q;
    end
  end

  // read data and interrupt requests
  wire rx_irq_d  = !standby &&
                   ((full_q && ctrl_b_q[`ASR_CB_FULL_IE]) ||
                    (idle_q && ctrl_b_q[`ASR_CB_IDLE_IE]));
  wire err_irq_d = !standby &&
                   ((or_q && ctrl_c_q[`ASR_CC_OR_IE]) ||
                    (nf_q && ctrl_c_q[`ASR_CC_NF_IE]) ||
                    (fe_q && ctrl_c_q[`ASR_CC_FE_IE]));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o   <= 8'h00;
      rx_irq_o  <= 1'b0;
      err_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      rdata_o   <= rd_i ? rd_mux : 8'h00;
      rx_irq_o  <= rx_irq_d;
      err_irq_o <= err_irq_d;
    end
  end

  default clocking a_clk @(posedge ref_clk_i iff clk_en_i);
  endclocking
  default disable iff (reset_i);

  a_fe_with_full:
    assert property ($rose(fe_q) |-> $rose(full_q))
    else $error("framing error rose without receive full");
  a_full_irq:
    assert property (full_q && ctrl_b_q[`ASR_CB_FULL_IE] && !standby
                     |=> rx_irq_o)
    else $error("receive full did not raise interrupt");
  a_standby_quiet:
    assert property (standby |=> !rx_irq_o && !err_irq_o)
    else $error("interrupt raised in standby");
  a_verify_fail:
    assert property (rx_on && rt_tick && state_q == asr_pkg::ASR_START &&
                     rt_q == `ASR_RT_VERIFY && maj3(trio)
                     |=> state_q == asr_pkg::ASR_HUNT)
    else $error("failed start verify did not restart search");
  a_start_noise:
    assert property (rx_on && rt_tick && state_q == asr_pkg::ASR_START &&
                     rt_q == `ASR_RT_VERIFY && !maj3(trio) && split3(trio)
                     |=> nf_acc_q && state_q == asr_pkg::ASR_START)
    else $error("start noise not noted");
  a_overrun_keep:
    assert property (overrun |=> or_q && $stable(buf_q))
    else $error("overrun lost old character or flag");
  a_ninth_copy:
    assert property (load && !len9 |=> ninth_q == buf_q[7])
    else $error("ninth bit not a copy of bit 7");
  a_mark_wake:
    assert property (wake_hit && !wr_b && !full_q |=> !standby && full_q)
    else $error("address mark did not wake");
  a_idle_wake:
    assert property (idle_wake && !wr_b |=> !standby ##0 !$rose(full_q))
    else $error("idle line did not wake cleanly");
  a_idle_silent:
    assert property (standby |=> !$rose(idle_q))
    else $error("idle flag set in standby");
  a_rt_range:
    assert property (state_q != asr_pkg::ASR_HUNT |->
                     rt_q >= `ASR_RT_FIRST && rt_q <= `ASR_RT_LAST)
    else $error("oversample count out of range");

  c_load: cover property (load ##1 rd_buf);
  c_overrun: cover property (overrun);
  c_break: cover property (load && is_break);
  c_wake: cover property (wake_hit or idle_wake);
endmodule // asr_receiver

/* verif/asr_serial_tx.sv */
`timescale 1ns/100ps
module asr_serial_tx #(
  parameter int unsigned BIT_CLKS = 64
) (
  input  wire logic ref_clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  // one bit time; line inverted for four clocks from glitch_at
  task automatic hold_bit(input logic v, input int glitch_at);
    for (int i = 0; i < BIT_CLKS; i++) begin
      @(posedge ref_clk_i);
      line_o <= (i >= glitch_at && i < glitch_at + 4) ? ~v : v;
    end
  endtask

  // start, data lsb first, stop, then one idle guard bit
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop, input int glitch_at);
    hold_bit(1'b0, -8);
    for (int b = 0; b < nbits; b++) begin
      hold_bit(data[b], (b == 0) ? glitch_at : -8);
    end
    hold_bit(stop, -8);
    hold_bit(1'b1, -8);
  endtask

  // short low pulse that must not pass as a start bit
  task automatic blip(input int clks);
    for (int i = 0; i < clks + 1; i++) begin
      @(posedge ref_clk_i);
      line_o <= (i == clks);
    end
  endtask
endmodule // asr_serial_tx

/* verif/async_serial_receiver_tb.sv */
`timescale 1ns/100ps
`include "asr_regs.svh"
`define ASR_CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); \
  end \
end
module async_serial_receiver_tb;
  localparam int unsigned DIV      = 3;
  localparam int unsigned BIT_CLKS = 16 * (DIV + 1);
  logic       ref_clk;
  logic       reset;
  logic       clk_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       pin;
  logic       rx_irq;
  logic       err_irq;
  int         n_mismatch;
  int         check_count;
  logic [7:0] d;
  logic [7:0] v;
  logic [8:0] v9;
  logic [7:0] ca;
  logic [7:0] cb;
  logic [7:0] cc;

  asr_receiver i_dut (
    .ref_clk_i     (ref_clk),
    .reset_i       (reset),
    .clk_en_i      (clk_en),
    .addr_i        (addr),
    .wdata_i       (wdata),
    .wr_i          (wr),
    .rd_i          (rd),
    .rdata_o       (rdata),
    .receive_pin_i (pin),
    .rx_irq_o      (rx_irq),
    .err_irq_o     (err_irq)
  );
  asr_serial_tx #(.BIT_CLKS(BIT_CLKS)) i_tx (
    .ref_clk_i (ref_clk),
    .line_o    (pin)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    x = rdata;
  endtask

  function automatic logic [7:0] flags_exp(bit full, bit idle, bit ovr,
                                          bit nf, bit fe);
    return {2'b00, full, idle, ovr, nf, fe, 1'b0};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic idle_wait(input int bits);
    repeat (bits * BIT_CLKS) @(posedge ref_clk);
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    d = $urandom(32'hA3EC);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 8'h13; a <= 8'h1A; a++) begin
      rd_reg(a[7:0], d);
      `ASR_CHK(d, 8'h00)
    end
    wr_reg(`ASR_ADDR_BUFFER, 8'hA5);
    wr_reg(8'h1A, 8'h5A);
    rd_reg(`ASR_ADDR_BUFFER, d);
    `ASR_CHK(d, 8'h00)
    wr_reg(`ASR_ADDR_BAUD, DIV[7:0]);
    rd_reg(`ASR_ADDR_BAUD, d);
    `ASR_CHK(d, DIV[7:0])
    ca = (8'h01 << `ASR_CA_ENABLE) | (8'h01 << `ASR_CA_IDLE_ORG);
    cb = (8'h01 << `ASR_CB_RX_EN) | (8'h01 << `ASR_CB_FULL_IE);
    cc = 8'h01 << `ASR_CC_FE_IE;
    wr_reg(`ASR_ADDR_CTRL_A, ca);
    wr_reg(`ASR_ADDR_CTRL_B, cb);
    wr_reg(`ASR_ADDR_CTRL_C, cc);
    idle_wait(1);
    i_tx.blip(6);
    idle_wait(20);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, 8'h00)
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
      i_tx.send({1'b0, v}, 8, 1'b1, -8);
      `ASR_CHK(rx_irq, 1'b1)
      rd_reg(`ASR_ADDR_FLAGS_A, d);
      `ASR_CHK(d, flags_exp(1, 0, 0, 0, 0))
      rd_reg(`ASR_ADDR_BUFFER, d);
      `ASR_CHK(d, v)
      rd_reg(`ASR_ADDR_CTRL_C, d);
      `ASR_CHK(d, {v[7], cc[6:0]})
      `ASR_CHK(rx_irq, 1'b0)
    end
    idle_wait(12);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, flags_exp(0, 1, 0, 0, 0))
    rd_reg(`ASR_ADDR_BUFFER, d);
    wr_reg(`ASR_ADDR_CTRL_A, ca | (8'h01 << `ASR_CA_CHAR_LEN));
    for (int k = 0; k < 2; k++) begin
      v9 = (k == 0) ? 9'h13C : 9'h0C3;
      i_tx.send(v9, 9, 1'b1, -8);
      rd_reg(`ASR_ADDR_BUFFER, d);
      `ASR_CHK(d, v9[7:0])
      rd_reg(`ASR_ADDR_CTRL_C, d);
      `ASR_CHK(d, {v9[8], cc[6:0]})
    end
    wr_reg(`ASR_ADDR_CTRL_A, ca);
    i_tx.send(9'h05A, 8, 1'b0, -8);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, flags_exp(1, 0, 0, 0, 1))
    `ASR_CHK(err_irq, 1'b1)
    rd_reg(`ASR_ADDR_BUFFER, d);
    `ASR_CHK(d, 8'h5A)
    i_tx.send(9'h000, 8, 1'b0, -8);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, flags_exp(1, 0, 0, 0, 1))
    rd_reg(`ASR_ADDR_FLAGS_B, d);
    `ASR_CHK(d, 8'h02)
    rd_reg(`ASR_ADDR_BUFFER, d);
    i_tx.send(9'h0A4, 8, 1'b1, 32);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, flags_exp(1, 0, 0, 1, 0))
    rd_reg(`ASR_ADDR_BUFFER, d);
    `ASR_CHK(d, 8'hA4)
    i_tx.send(9'h011, 8, 1'b1, -8);
    i_tx.send(9'h022, 8, 1'b1, -8);
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, flags_exp(1, 0, 1, 0, 0))
    rd_reg(`ASR_ADDR_BUFFER, d);
    `ASR_CHK(d, 8'h11)
    wr_reg(`ASR_ADDR_CTRL_A, ca | (8'h01 << `ASR_CA_WAKE));
    wr_reg(`ASR_ADDR_CTRL_B, cb | (8'h01 << `ASR_CB_STANDBY));
    i_tx.send(9'h035, 8, 1'b1, -8);
    `ASR_CHK(rx_irq, 1'b0)
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, 8'h00)
    i_tx.send(9'h0B5, 8, 1'b1, -8);
    `ASR_CHK(rx_irq, 1'b1)
    rd_reg(`ASR_ADDR_CTRL_B, d);
    `ASR_CHK(d, cb)
    rd_reg(`ASR_ADDR_BUFFER, d);
    `ASR_CHK(d, 8'hB5)
    wr_reg(`ASR_ADDR_CTRL_A, ca);
    wr_reg(`ASR_ADDR_CTRL_B, cb | (8'h01 << `ASR_CB_STANDBY));
    idle_wait(12);
    rd_reg(`ASR_ADDR_CTRL_B, d);
    `ASR_CHK(d, cb)
    rd_reg(`ASR_ADDR_FLAGS_A, d);
    `ASR_CHK(d, 8'h00)
    complete_run();
  end
endmodule // async_serial_receiver_tb
